// ---- hdl/pfd_divider.sv ----
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
// What this block does
// - Enable bit 4 drives tone onto pin; cleared holds the pin low.
// - Control bits 6:5 pick prescale divide of 1, 2, 4 or 8.
// - Control bit 7 picks fast clock over four, else the 32768Hz tick.
// - Prescaler output feeds counter reloaded from 8-bit read/write value N.
// - Writes to the reload value are ignored while disabled.
// - While disabled the reload value is cleared to zero by hardware.
// - Control bits 3:0 read zero and ignore writes.
module pfd_divider
	import pfd_pkg::*;
(
	input  wire logic         clk_i,
	input  wire logic         reset_n_i,
	input  wire logic         slow_tick_i,
	input  pfd_pkg::pfd_apb_req_t apb_req_i,
	output pfd_pkg::pfd_apb_rsp_t apb_rsp_o,
	output logic              tone_out_pin_o
);

	////////////////////////////////////////////////////////////////////////

	logic [7:0] divider_control_r;
	logic [7:0] divider_reload_value_r;
	logic [7:0] control_nxt;
	logic [7:0] reload_nxt;
	logic [1:0] hs_count_r;
	logic       hs_tick_r;
	logic       pready_r;
	logic       pslverr_r;
	logic [31:0] prdata_r;
	logic       tone_out_pin_r;

	pfd_ctrl_t  ctrl;
	logic       access;
	logic       wr;
	logic       hit_ctrl;
	logic       hit_reload;
	logic       mapped;
	logic [31:0] rd_data;
	logic       src_tick;
	logic       pres_tick;
	logic       tone;
	logic       hold;

	////////////////////////////////////////////////////////////////////////

	assign access     = apb_req_i.psel && apb_req_i.penable && !pready_r;
	// A write lands on the edge at which the master samples pready high.
	assign wr         = apb_req_i.psel && apb_req_i.penable && pready_r &&
	                    apb_req_i.pwrite;
	assign hit_ctrl   = apb_req_i.paddr == ADDR_CONTROL;
	assign hit_reload = apb_req_i.paddr == ADDR_RELOAD;
	assign mapped     = hit_ctrl || hit_reload;

	assign ctrl.src_sel = divider_control_r[BIT_SRC_SEL];
	assign ctrl.pres    = {divider_control_r[BIT_PRES_HI],
	                       divider_control_r[BIT_PRES_LO]};
	assign ctrl.enable  = divider_control_r[BIT_ENABLE];
	assign hold         = !ctrl.enable;

	assign control_nxt = (wr && hit_ctrl) ?
	                     (apb_req_i.pwdata[7:0] & CTRL_MASK) :
	                     divider_control_r;

	// Clearing happens whenever the enable is low, so a write in that
	// state is both ignored and overwritten with zero.
	assign reload_nxt = hold ? 8'h00 :
	                    ((wr && hit_reload) ? apb_req_i.pwdata[7:0]
	                                        : divider_reload_value_r);

	assign rd_data = hit_ctrl   ? {24'h0, divider_control_r} :
	                 hit_reload ? {24'h0, divider_reload_value_r} :
	                              32'h0;

	// Source pick between the divided fast clock and the slow tick.
	assign src_tick = ctrl.src_sel ? hs_tick_r : slow_tick_i;

	////////////////////////////////////////////////////////////////////////

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			divider_control_r      <= CTRL_RESET;
			divider_reload_value_r <= RELOAD_RESET;
		end else begin
			divider_control_r      <= control_nxt;
			divider_reload_value_r <= reload_nxt;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0;
		end else begin
			pready_r  <= access;
			pslverr_r <= access && !mapped;
			prdata_r  <= (access && !apb_req_i.pwrite) ? rd_data : 32'h0;
		end
	end

	// Free-running fast-clock divide by four.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			hs_count_r <= 2'h0;
			hs_tick_r  <= 1'b0;
		end else begin
			hs_count_r <= 2'(hs_count_r + 2'h1);
			hs_tick_r  <= hs_count_r == HS_LAST;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tone_out_pin_r <= 1'b0;
		end else begin
			tone_out_pin_r <= ctrl.enable && tone;
		end
	end

	////////////////////////////////////////////////////////////////////////

	pfd_prescaler u_prescaler (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.clear_i   (hold),
		.tick_i    (src_tick),
		.pres_i    (ctrl.pres),
		.tick_o    (pres_tick)
	);

	pfd_tone_counter #(
		.WIDTH (8)
	) u_counter (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.clear_i   (hold),
		.tick_i    (pres_tick),
		.reload_i  (divider_reload_value_r),
		.tone_o    (tone)
	);

	assign apb_rsp_o.pready  = pready_r;
	assign apb_rsp_o.pslverr = pslverr_r;
	assign apb_rsp_o.prdata  = prdata_r;
	assign tone_out_pin_o    = tone_out_pin_r;

endmodule

// ---- hdl/pfd_pkg.sv ----
package pfd_pkg;

	localparam int unsigned ADDR_W = 12;

	// Printed offsets are not multiples of four: they are register indices.
	localparam logic [7:0] IDX_CONTROL = 8'h2E;
	localparam logic [7:0] IDX_RELOAD  = 8'h2F;
	localparam logic [ADDR_W-1:0] ADDR_CONTROL = {2'h0, IDX_CONTROL, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_RELOAD  = {2'h0, IDX_RELOAD, 2'h0};

	localparam int unsigned BIT_ENABLE  = 4;
	localparam int unsigned BIT_PRES_LO = 5;
	localparam int unsigned BIT_PRES_HI = 6;
	localparam int unsigned BIT_SRC_SEL = 7;
	localparam logic [7:0]  CTRL_MASK   = 8'hF0;

	localparam logic [7:0] CTRL_RESET   = 8'h00;
	localparam logic [7:0] RELOAD_RESET = 8'h00;

	// High-speed source is the fast clock divided by four.
	localparam int unsigned HS_DIV = 4;
	localparam logic [1:0] HS_LAST = 2'(HS_DIV - 1);

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} pfd_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} pfd_apb_rsp_t;

	typedef struct packed {
		logic       src_sel;
		logic [1:0] pres;
		logic       enable;
	} pfd_ctrl_t;

endpackage

// ---- hdl/pfd_prescaler.sv ----
`timescale 1ns/1ps
module pfd_prescaler
	import pfd_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       clear_i,
	input  wire logic       tick_i,
	input  wire logic [1:0] pres_i,
	output logic            tick_o
);

	logic [2:0] count_r;
	logic [2:0] last;
	logic [2:0] count_nxt;
	logic       wrap;

	// Divide by 1, 2, 4 or 8.
	assign last      = 3'((4'h1 << pres_i) - 4'h1);
	assign wrap      = tick_i && (count_r >= last);
	assign count_nxt = clear_i ? 3'h0 : (wrap ? 3'h0 :
	                   (tick_i ? 3'(count_r + 3'h1) : count_r));

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count_r <= 3'h0;
			tick_o  <= 1'b0;
		end else begin
			count_r <= count_nxt;
			tick_o  <= wrap && !clear_i;
		end
	end

endmodule

// ---- hdl/pfd_tone_counter.sv ----
`timescale 1ns/1ps
module pfd_tone_counter
	import pfd_pkg::*;
#(
	parameter int unsigned WIDTH = 8
)(
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	input  wire logic             clear_i,
	input  wire logic             tick_i,
	input  wire logic [WIDTH-1:0] reload_i,
	output logic                  tone_o
);

	if (WIDTH < 1 || WIDTH > 16) begin : g_width_check
		$error("pfd_tone_counter: WIDTH must be 1..16");
	end

	logic [WIDTH-1:0] count_r;
	logic             reload;

	assign reload = tick_i && (count_r == '0);

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count_r <= '0;
			tone_o  <= 1'b0;
		end else if (clear_i) begin
			count_r <= '0;
			tone_o  <= 1'b0;
		end else if (reload) begin
			count_r <= reload_i;
			tone_o  <= !tone_o;
		end else if (tick_i) begin
			count_r <= count_r - 1'b1;
		end
	end

endmodule

// ---- testbench/pfd_divider_monitor.sv ----
`timescale 1ns/1ps
module pfd_divider_monitor
	import pfd_pkg::*;
(
	input wire logic    clk_i,
	input wire logic    reset_n_i,
	input wire logic    slow_tick_i,
	input pfd_apb_req_t apb_req_i,
	input pfd_apb_rsp_t apb_rsp_o,
	input wire logic    tone_out_pin_o
);
	logic en_r;
	wire  rdy = apb_rsp_o.pready;
	wire  acc = apb_req_i.psel && apb_req_i.penable;
	wire  rd  = rdy && !apb_req_i.pwrite;
	wire  ctl = apb_req_i.paddr == ADDR_CONTROL;
	wire  rld = apb_req_i.paddr == ADDR_RELOAD;
	// Shadow of the enable bit, taken from completed control writes.
	always_ff @(posedge clk_i or negedge reset_n_i)
		if (!reset_n_i) en_r <= 1'b0;
		else if (rdy && !rd && ctl) en_r <= apb_req_i.pwdata[BIT_ENABLE];
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	property p_off; (!en_r)[*6] |-> !tone_out_pin_o; endproperty
	a_off: assert property (p_off) else $error("tone on");
	property p_one; rdy |=> !rdy; endproperty
	a_one: assert property (p_one) else $error("long ready");
	property p_cause; rdy |-> acc && $past(acc); endproperty
	a_cause: assert property (p_cause) else $error("early ready");
	property p_err; rdy |-> apb_rsp_o.pslverr == !(ctl || rld); endproperty
	a_err: assert property (p_err) else $error("bad error");
	property p_idle; !rdy |-> !apb_rsp_o.pslverr && !apb_rsp_o.prdata; endproperty
	a_idle: assert property (p_idle) else $error("idle output");
	property p_ctl; rd && ctl |-> apb_rsp_o.prdata[3:0] == 4'h0; endproperty
	a_ctl: assert property (p_ctl) else $error("low bits");
	property p_rld; rd && rld && !en_r |-> apb_rsp_o.prdata == 32'h0; endproperty
	a_rld: assert property (p_rld) else $error("reload kept");
	property p_hi; rdy |-> apb_rsp_o.prdata[31:8] == 24'h0; endproperty
	a_hi: assert property (p_hi) else $error("upper bits");
	cover property (rd && rld && en_r);
	cover property (rdy && !(ctl || rld));
	cover property ($rose(tone_out_pin_o));
endmodule
bind pfd_divider pfd_divider_monitor i_pfd_divider_monitor (.clk_i(clk_i),
	.reset_n_i(reset_n_i), .slow_tick_i(slow_tick_i), .apb_req_i(apb_req_i),
	.apb_rsp_o(apb_rsp_o), .tone_out_pin_o(tone_out_pin_o));

// ---- testbench/test_programmable_frequency_divider.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
	error_cnt++; $display("ERROR %0t got %h exp %h", $time, a, e); end end
module test_programmable_frequency_divider;
	import pfd_pkg::*;
	logic         clk_i = 1'b0;
	logic         reset_n_i = 1'b0;
	logic         slow_tick_i = 1'b0;
	pfd_apb_req_t apb_req_i = '0;
	pfd_apb_rsp_t apb_rsp_o;
	logic         tone_out_pin_o;
	int           error_cnt = 0;
	int           samples_checked = 0;
	int           cyc = 0;
	int           n;
	int           c;
	logic [32:0]  exp_q[$];

	pfd_divider i_pfd_divider (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.slow_tick_i(slow_tick_i), .apb_req_i(apb_req_i),
		.apb_rsp_o(apb_rsp_o), .tone_out_pin_o(tone_out_pin_o));

	always #2.5 clk_i = ~clk_i;

	task end_sim;
		if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// Slow source pulses every 7 clocks; the cycle ceiling cuts a hang.
	always @(posedge clk_i) begin
		cyc++;
		slow_tick_i <= (cyc % 7 == 0);
		if (cyc == 40000) begin
			error_cnt++;
			end_sim();
		end
	end

	always @(posedge clk_i)
		if (apb_rsp_o.pready === 1'b1 && exp_q.size() > 0)
			`CHK({apb_rsp_o.pslverr, apb_rsp_o.prdata}, exp_q.pop_front())

	task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d,
		input logic [32:0] e);
		exp_q.push_back(e);
		apb_req_i.psel <= 1'b1;
		apb_req_i.pwrite <= w;
		apb_req_i.paddr <= a;
		apb_req_i.pwdata <= {24'($urandom), d};
		@(posedge clk_i);
		apb_req_i.penable <= 1'b1;
		do @(posedge clk_i); while (apb_rsp_o.pready !== 1'b1);
		apb_req_i.psel <= 1'b0;
		apb_req_i.penable <= 1'b0;
		@(posedge clk_i);
	endtask

	initial begin
		void'($urandom(87462));
		repeat (2) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		apb(0, ADDR_CONTROL, 8'h00, 33'h0);
		apb(1, ADDR_RELOAD, 8'h55, 33'h0);
		apb(0, ADDR_RELOAD, 8'h00, 33'h0);
		apb(1, ADDR_CONTROL, 8'hEF, 33'h0);
		apb(0, ADDR_CONTROL, 8'h00, 33'hE0);
		apb(1, 12'h000, 8'hFF, 33'h1_0000_0000);
		apb(0, 12'h000, 8'h00, 33'h1_0000_0000);
		`CHK(tone_out_pin_o, 1'b0)
		for (int s = 0; s < 2; s++) begin
			for (int p = 0; p < 4; p++) begin
				n = $urandom_range(7);
				apb(1, ADDR_CONTROL, {s[0], p[1:0], 5'h10}, 33'h0);
				c = $urandom_range(255);
				apb(1, ADDR_RELOAD, c[7:0], 33'h0);
				apb(0, ADDR_RELOAD, 8'h00, {25'h0, c[7:0]});
				apb(1, ADDR_RELOAD, n[7:0], 33'h0);
				apb(0, ADDR_RELOAD, 8'h00, {25'h0, n[7:0]});
				@(posedge tone_out_pin_o);
				@(posedge tone_out_pin_o);
				c = 0;
				@(negedge clk_i);
				while (tone_out_pin_o) begin
					c++;
					@(negedge clk_i);
				end
				`CHK(c, (n + 1) * (1 << p) * (s ? 4 : 7))
				apb(1, ADDR_CONTROL, 8'h00, 33'h0);
				apb(0, ADDR_RELOAD, 8'h00, 33'h0);
				`CHK(tone_out_pin_o, 1'b0)
			end
		end
		end_sim();
	end
endmodule
